// file: hw/ssa_readout.sv
// Conversion control and serial readout of a 12-bit successive approximation.
`timescale 1ns/10ps
module ssa_readout (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic data_clock,
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic [ssa_pkg::RES_W-1:0] smp_data,
  output ssa_pkg::ssa_pin_out_t pin_out,
  output ssa_pkg::ssa_power_t power
);
  import ssa_pkg::*;

  //----------------------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------------------
  ssa_core_t core_ff; // Registered state of the core.
  ssa_core_t nxt_core; // Next value of that state, before the lower bit decision pass.
  logic fifo_ready; // Buffer can take a sample word.
  logic fifo_valid; // Buffer holds a sample word.
  logic [RES_W-1:0] fifo_data; // Oldest sample word.
  logic cs_fall; // Select went low, synchronised.
  logic cs_rise; // Select went high, synchronised.
  logic dclk_fall; // Data clock fell, synchronised.
  logic [RES_W-1:0] trial; // Trial code for the current bit.
  logic decide; // Comparator outcome for the current bit.

  //----------------------------------------------------------------------------
  // Sample buffer
  //----------------------------------------------------------------------------
  // Words from the front end wait here; only one is taken per conversion,
  // so the buffer fills and its ready throttles the source.
  ssa_fifo #(
    .W(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(smp_valid),
    .in_ready(fifo_ready),
    .in_data(smp_data),
    .out_valid(fifo_valid),
    .out_ready(core_ff.pop),
    .out_data(fifo_data)
  );

  //----------------------------------------------------------------------------
  // Edge detection
  //----------------------------------------------------------------------------
  // Only the second synchroniser stage and its delayed copy are compared.
  assign cs_fall = core_ff.cs_prev && !core_ff.cs_sync;
  assign cs_rise = !core_ff.cs_prev && core_ff.cs_sync;
  assign dclk_fall = core_ff.dclk_prev && !core_ff.dclk_sync;

  //----------------------------------------------------------------------------
  // Bit decision
  //----------------------------------------------------------------------------
  // The trial code sets the bit under test on top of the bits decided so
  // far; the held sample is compared against it as the comparator would.
  always_comb
  begin
    trial = core_ff.result;
    trial[core_ff.idx] = 1'b1;
    decide = (core_ff.hold >= trial);
  end

  //----------------------------------------------------------------------------
  // Sequencer
  //----------------------------------------------------------------------------
  always_comb
  begin
    nxt_core = core_ff;
    nxt_core.cs_meta = cs_n;
    nxt_core.cs_sync = core_ff.cs_meta;
    nxt_core.cs_prev = core_ff.cs_sync;
    nxt_core.dclk_meta = data_clock;
    nxt_core.dclk_sync = core_ff.dclk_meta;
    nxt_core.dclk_prev = core_ff.dclk_sync;
    nxt_core.pop = 1'b0;
    // Take the word popped in this cycle; an empty buffer keeps
    // the last held value rather than inventing one.
    if (core_ff.pop && fifo_valid)
    begin
      nxt_core.hold = fifo_data;
    end
    if (core_ff.cs_sync)
    begin
      // Select high: everything stops and the pin floats.
      nxt_core.state = SSA_IDLE;
      nxt_core.pins.dout_oe = 1'b0;
      nxt_core.pins.dout = 1'b0;
    end
    else if (cs_fall)
    begin
      // A fresh fall is the only way into a new conversion.
      nxt_core.state = SSA_SAMPLE;
      nxt_core.fall_cnt = 2'h0;
      nxt_core.result = CODE_ZERO;
      nxt_core.idx = TOP_IDX;
      nxt_core.pins.dout_oe = 1'b0;
    end
    else if (dclk_fall)
    begin
      unique case (core_ff.state)
        SSA_IDLE:
        begin
          // Select low without a seen fall; wait for a proper restart.
          nxt_core.state = SSA_IDLE;
        end
        SSA_SAMPLE:
        begin
          // The input tracks for the first two clock periods.
          nxt_core.fall_cnt = 2'(core_ff.fall_cnt + 1'b1);
          if (2'(core_ff.fall_cnt + 1'b1) == SAMPLE_FALLS)
          begin
            nxt_core.pop = 1'b1;
            nxt_core.state = SSA_NULL;
            nxt_core.pins.dout_oe = 1'b1;
            nxt_core.pins.dout = 1'b0;
          end
        end
        SSA_NULL:
        begin
          // The top bit is decided and shown on the same edge.
          nxt_core.result[TOP_IDX] = decide;
          nxt_core.pins.dout = decide;
          nxt_core.state = SSA_MSB;
        end
        SSA_MSB:
        begin
          if (core_ff.idx == BOTTOM_IDX)
          begin
            // The bottom bit was last; repeat from bit one upward.
            nxt_core.idx = FIRST_REPEAT_IDX;
            nxt_core.pins.dout = core_ff.result[FIRST_REPEAT_IDX];
            nxt_core.state = SSA_LSB;
          end
          else
          begin
            nxt_core.idx = 4'(core_ff.idx - 1'b1);
            nxt_core.result[core_ff.idx - 1'b1] = 1'b0;
            nxt_core.state = SSA_MSB;
          end
        end
        SSA_LSB:
        begin
          if (core_ff.idx == TOP_IDX)
          begin
            // Top bit repeated: float and go deaf to the clock.
            nxt_core.pins.dout_oe = 1'b0;
            nxt_core.state = SSA_DONE;
          end
          else
          begin
            nxt_core.idx = 4'(core_ff.idx + 1'b1);
            nxt_core.pins.dout = core_ff.result[core_ff.idx + 1'b1];
          end
        end
        SSA_DONE:
        begin
          // Further clocks change nothing until select cycles.
          nxt_core.state = SSA_DONE;
        end
        default:
        begin
          nxt_core.state = SSA_IDLE;
        end
      endcase
    end
    // The bit decision for a lower bit is made by the second pass below in the
    // same cycle as the index moves, so the new bit goes out in the cycle after the edge.
    if (!core_ff.cs_sync && !cs_fall && core_ff.state == SSA_MSB &&
        core_ff.pop == 1'b0 && core_ff.pins.dout_oe && dclk_fall &&
        core_ff.idx != BOTTOM_IDX)
    begin
      nxt_core.pins.dout = 1'b0;
    end
    // Analog section idles outside sampling and converting.
    nxt_core.power.analog_pd = (nxt_core.state == SSA_IDLE) ||
                               (nxt_core.state == SSA_DONE);
    // Digital section sleeps only while select is high.
    nxt_core.power.digital_pd = core_ff.cs_sync;
  end

  //----------------------------------------------------------------------------
  // Lower bit decision
  //----------------------------------------------------------------------------
  // A small second pass: once the index has stepped down, the bit under it
  // is decided here and driven, so the pin follows each decision at once.
  ssa_core_t dec_core;
  always_comb
  begin
    dec_core = nxt_core;
    if (core_ff.state == SSA_MSB && dclk_fall && !core_ff.cs_sync &&
        !cs_fall && core_ff.idx != BOTTOM_IDX)
    begin
      dec_core.result[nxt_core.idx] = (core_ff.hold >=
        (core_ff.result | (RES_W'(1) << nxt_core.idx)));
      dec_core.pins.dout = dec_core.result[nxt_core.idx];
    end
  end

  // State register; the select pin resets to its idle level.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      core_ff <= '0;
      core_ff.cs_meta <= 1'b1;
      core_ff.cs_sync <= 1'b1;
      core_ff.cs_prev <= 1'b1;
      core_ff.state <= SSA_IDLE;
      core_ff.power.analog_pd <= 1'b1;
      core_ff.power.digital_pd <= 1'b1;
    end
    else
    begin
      core_ff <= dec_core;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  assign pin_out = core_ff.pins;
  assign power = core_ff.power;
  assign smp_ready = fifo_ready;

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_cs_fall;
    !core_ff.cs_sync && core_ff.cs_prev;
  endsequence

  sequence s_fall_in(ssa_state_t st);
    dclk_fall && !core_ff.cs_sync && !cs_fall && core_ff.state == st;
  endsequence

  property p_float_cs_high;
    core_ff.cs_sync |=> !pin_out.dout_oe;
  endproperty
  a_float_cs_high: assert property (p_float_cs_high)
    else $error("Output driven while select high.");

  property p_start;
    s_cs_fall |=> core_ff.state == SSA_SAMPLE && !pin_out.dout_oe;
  endproperty
  a_start: assert property (p_start)
    else $error("Select fall did not start a conversion.");

  property p_sample_float;
    core_ff.state == SSA_SAMPLE |-> !pin_out.dout_oe;
  endproperty
  a_sample_float: assert property (p_sample_float)
    else $error("Output enabled inside the sample window.");

  property p_null;
    s_fall_in(SSA_SAMPLE) ##0 (core_ff.fall_cnt == 2'h1) |=>
      pin_out.dout_oe && !pin_out.dout && core_ff.state == SSA_NULL;
  endproperty
  a_null: assert property (p_null)
    else $error("Null bit not driven low after second fall.");

  property p_msb_step;
    s_fall_in(SSA_MSB) ##0 (core_ff.idx != BOTTOM_IDX) |=>
      core_ff.idx == 4'($past(core_ff.idx) - 1'b1);
  endproperty
  a_msb_step: assert property (p_msb_step)
    else $error("Top-first order broken.");

  // The pin must carry the decided bit and match the held sample's bit.
  property p_bit_shown;
    s_fall_in(SSA_MSB) |=> pin_out.dout == core_ff.result[core_ff.idx] &&
      pin_out.dout == core_ff.hold[core_ff.idx];
  endproperty
  a_bit_shown: assert property (p_bit_shown)
    else $error("Decided bit not on the pin.");

  property p_lsb_step;
    s_fall_in(SSA_LSB) ##0 (core_ff.idx != TOP_IDX) |=>
      core_ff.idx == 4'($past(core_ff.idx) + 1'b1) &&
      pin_out.dout == core_ff.result[core_ff.idx];
  endproperty
  a_lsb_step: assert property (p_lsb_step)
    else $error("Bottom-first repeat broken.");

  property p_end_float;
    s_fall_in(SSA_LSB) ##0 (core_ff.idx == TOP_IDX) |=>
      !pin_out.dout_oe && core_ff.state == SSA_DONE;
  endproperty
  a_end_float: assert property (p_end_float)
    else $error("Output not floated after repeated top bit.");

  property p_no_retrigger;
    core_ff.state == SSA_DONE && !core_ff.cs_sync |=>
      core_ff.state == SSA_DONE;
  endproperty
  a_no_retrigger: assert property (p_no_retrigger)
    else $error("Conversion retriggered without select cycling.");

  property p_abort;
    cs_rise |=> core_ff.state == SSA_IDLE ##1 power.digital_pd &&
      power.analog_pd;
  endproperty
  a_abort: assert property (p_abort)
    else $error("Early termination did not power down.");

  property p_code;
    $rose(core_ff.state == SSA_LSB) |-> core_ff.result == core_ff.hold;
  endproperty
  a_code: assert property (p_code)
    else $error("Result differs from straight binary of sample.");

  property p_power;
    core_ff.state == SSA_DONE && !core_ff.cs_sync && !cs_rise |=>
      power.analog_pd && !power.digital_pd;
  endproperty
  a_power: assert property (p_power)
    else $error("Wrong power state after completion.");

  // Outside a seen clock fall or a high select the pin level must hold.
  property p_dout_holds;
    !dclk_fall && !core_ff.cs_sync |=> $stable(pin_out.dout);
  endproperty
  a_dout_holds: assert property (p_dout_holds)
    else $error("Serial output moved without a data clock fall.");

  // The null bit lasts one period; the next fall shows the top decision.
  property p_null_top;
    s_fall_in(SSA_NULL) |=> core_ff.state == SSA_MSB &&
      pin_out.dout_oe && pin_out.dout == core_ff.hold[TOP_IDX];
  endproperty
  a_null_top: assert property (p_null_top)
    else $error("Top result bit not shown after the null bit.");

  // Sampling and converting keep the analog section awake.
  property p_analog_on;
    core_ff.state != SSA_IDLE && core_ff.state != SSA_DONE |->
      !power.analog_pd;
  endproperty
  a_analog_on: assert property (p_analog_on)
    else $error("Analog section asleep during a conversion.");

  // Select high puts both sections to sleep one cycle later.
  property p_select_high_pd;
    core_ff.cs_sync |=> power.analog_pd && power.digital_pd;
  endproperty
  a_select_high_pd: assert property (p_select_high_pd)
    else $error("Select high without full power down.");

endmodule

// file: hw/ssa_pkg.sv
// Shared constants, states and carrier types of the serial converter readout.
//------------------------------------------------------------------------------
// Notes on behaviour
// - Serial output advances on data_clock falling edges.
// - Falling select starts conversion and transfer.
// - Input sampled during first two clock periods.
// - Null bit driven low after second fall.
// - Twelve result bits follow, top bit first.
// - Then result repeats, bottom bit first.
// - After repeated top bit, output floats; ignore clocks.
// - Restart only after select high then low.
// - Each bit appears as soon as decided.
// - Raising select early abandons conversion, powers down.
// - Result coded as unsigned straight binary.
// - Ideal codes FFF, 800 and 000.
// - Power down on completion or select high.
// - Digital section powers down only with select high.
//------------------------------------------------------------------------------
package ssa_pkg;

  // Width of a conversion result and the index of its top bit.
  localparam int RES_W = 12;
  localparam logic [3:0] TOP_IDX = 4'hB;
  localparam logic [3:0] BOTTOM_IDX = 4'h0;
  localparam logic [3:0] FIRST_REPEAT_IDX = 4'h1;

  // Depth of the sample buffer in front of the converter.
  localparam int FIFO_DEPTH = 32;

  // Number of data_clock falls that close the sample window.
  localparam logic [1:0] SAMPLE_FALLS = 2'h2;

  // Ideal straight binary codes.
  localparam logic [RES_W-1:0] CODE_ZERO = 12'h000;
  localparam logic [RES_W-1:0] CODE_MID = 12'h800;
  localparam logic [RES_W-1:0] CODE_FULL = 12'hFFF;

  // Sequencer states, Gray coded along the normal path.
  typedef enum logic [2:0] {
    SSA_IDLE = 3'h0,
    SSA_SAMPLE = 3'h1,
    SSA_NULL = 3'h3,
    SSA_MSB = 3'h2,
    SSA_LSB = 3'h6,
    SSA_DONE = 3'h7
  } ssa_state_t;

  // Serial output pin as drive value plus enable.
  typedef struct packed {
    logic dout;
    logic dout_oe;
  } ssa_pin_out_t;

  // Power-down indications of the two sections.
  typedef struct packed {
    logic analog_pd;
    logic digital_pd;
  } ssa_power_t;

  // Whole state of the readout core.
  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic dclk_meta;
    logic dclk_sync;
    logic dclk_prev;
    ssa_state_t state;
    logic [1:0] fall_cnt;
    logic [3:0] idx;
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] hold;
    logic pop;
    ssa_pin_out_t pins;
    ssa_power_t power;
  } ssa_core_t;

endpackage

// file: hw/ssa_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module ssa_fifo #(
  parameter int W = 12,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // All state in one record; ready is kept in a flop so it can leave the top.
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic ready;
  } ssa_fifo_t;

  ssa_fifo_t fifo_ff;
  ssa_fifo_t nxt_fifo;
  logic push;
  logic pop;

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  // Push and pop may meet in one cycle; the count then stays put.
  always_comb
  begin
    nxt_fifo = fifo_ff;
    push = in_valid && fifo_ff.ready;
    pop = out_ready && (fifo_ff.count != '0);
    if (push)
    begin
      nxt_fifo.mem[fifo_ff.wr_ptr] = in_data;
      nxt_fifo.wr_ptr = AW'(fifo_ff.wr_ptr + 1'b1);
    end
    if (pop)
    begin
      nxt_fifo.rd_ptr = AW'(fifo_ff.rd_ptr + 1'b1);
    end
    if (push && !pop)
    begin
      nxt_fifo.count = (AW+1)'(fifo_ff.count + 1'b1);
    end
    else if (pop && !push)
    begin
      nxt_fifo.count = (AW+1)'(fifo_ff.count - 1'b1);
    end
    nxt_fifo.ready = (nxt_fifo.count != (AW+1)'(DEPTH));
  end

  // State register.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      fifo_ff <= '0;
      fifo_ff.ready <= 1'b1;
    end
    else
    begin
      fifo_ff <= nxt_fifo;
    end
  end

  assign in_ready = fifo_ff.ready;
  assign out_valid = (fifo_ff.count != '0);
  assign out_data = fifo_ff.mem[fifo_ff.rd_ptr];

endmodule

// file: dv/ssa_host_model.sv
// Host side model: drives select and data_clock, samples the serial line.
`timescale 1ns/10ps
module ssa_host_model (
  input wire logic clk_sys,
  input wire ssa_pkg::ssa_pin_out_t pin_out,
  input wire ssa_pkg::ssa_power_t power,
  output logic cs_n,
  output logic data_clock
);
  import ssa_pkg::*;
  // Last level the device drove; the line has no pull resistor.
  logic last_d = 1'b0;
  // Level the host sees on the line.
  logic line_lvl;
  // Enable and level seen at each rising data_clock edge of a frame.
  logic [1:0] cap_line [0:31];
  // Power flags seen at each rising data_clock edge of a frame.
  ssa_power_t cap_pw [0:31];

  initial
  begin
    cs_n = 1'b1;
    data_clock = 1'b0;
  end

  // A released line must not look like it still holds the old bit.
  always @(posedge clk_sys)
    if (pin_out.dout_oe)
      last_d <= pin_out.dout;
  assign line_lvl = pin_out.dout_oe ? pin_out.dout : ~last_d;

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  //----------------------------------------------------------------------------
  // Frame tasks
  //----------------------------------------------------------------------------
  // Select falls with the clock low, then nf falls; ends on a rising edge.
  task automatic frame(input int nf, input int half);
    cs_n = 1'b0;
    for (int k = 1; k <= nf + 1; k++)
    begin
      wait_clk(half);
      data_clock = 1'b1;
      cap_line[k] = {pin_out.dout_oe, line_lvl};
      cap_pw[k] = power;
      if (k <= nf)
      begin
        wait_clk(half);
        data_clock = 1'b0;
      end
    end
  endtask

  // Raising select ends or aborts a frame; the clock then parks low.
  task automatic end_frame(input int half);
    cs_n = 1'b1;
    wait_clk(half);
    data_clock = 1'b0;
    wait_clk(half);
  endtask
endmodule

// file: dv/tb_top.sv
// Self-checking testbench of the serial converter readout.
`timescale 1ns/10ps
module tb_top;
  import ssa_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cs_n;
  logic data_clock;
  logic smp_valid = 1'b0;
  logic smp_ready;
  logic [RES_W-1:0] smp_data = 12'h000;
  ssa_pin_out_t pin_out;
  ssa_power_t power;
  int n_fail = 0;
  int total_checks = 0;
  int seed = 22;
  int cycles = 0;
  // Words the converter should report, oldest first.
  logic [RES_W-1:0] exp_q [$];

  always #5 clk_sys = ~clk_sys;

  ssa_readout ssa_readout_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .cs_n(cs_n),
    .data_clock(data_clock),
    .smp_valid(smp_valid),
    .smp_ready(smp_ready),
    .smp_data(smp_data),
    .pin_out(pin_out),
    .power(power)
  );

  ssa_host_model ssa_host_model_i (
    .clk_sys(clk_sys),
    .pin_out(pin_out),
    .power(power),
    .cs_n(cs_n),
    .data_clock(data_clock)
  );

  //----------------------------------------------------------------------------
  // Checking and closing
  //----------------------------------------------------------------------------
  task automatic chk1(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Whole run needs under 20000 cycles; twice that means a hang.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_fail++;
      stop_test();
    end
  end

  // Expected {enable, level} at rising edge k of a frame carrying w.
  function automatic logic [1:0] exp_line(input logic [RES_W-1:0] w,
                                          input int k);
    if (k == 3)
      return 2'h2;
    if (k >= 4 && k <= 15)
      return {1'b1, w[15-k]};
    if (k >= 16 && k <= 26)
      return {1'b1, w[k-15]};
    return 2'h0;
  endfunction

  //----------------------------------------------------------------------------
  // Stimulus tasks
  //----------------------------------------------------------------------------
  // Offers one word for a cycle; want is whether the buffer should take it.
  task automatic push(input logic [RES_W-1:0] w, input logic want);
    @(negedge clk_sys);
    smp_valid = 1'b1;
    smp_data = w;
    chk1(smp_ready, want, "buffer ready");
    if (smp_ready === 1'b1)
      exp_q.push_back(w);
    @(negedge clk_sys);
    smp_valid = 1'b0;
  endtask

  // One frame of nf falls, checked edge by edge, then select is raised.
  task automatic run_frame(input int nf, input int half);
    logic [RES_W-1:0] w;
    logic [1:0] e;
    logic [1:0] g;
    // A word leaves the buffer only once the sample window has closed.
    w = (nf >= 2) ? exp_q.pop_front() : 12'h000;
    @(negedge clk_sys);
    ssa_host_model_i.frame(nf, half);
    for (int k = 1; k <= nf + 1; k++)
    begin
      e = exp_line(w, k);
      g = ssa_host_model_i.cap_line[k];
      chk1(g[1], e[1], "output enable");
      if (e[1])
        chk1(g[0], e[0], "serial bit");
    end
    if (nf >= 5)
    begin
      g = ssa_host_model_i.cap_pw[5];
      chk1(g[1], 1'b0, "analog on in frame");
      chk1(g[0], 1'b0, "digital on in frame");
    end
    // Select still low after completion: only the analog part sleeps.
    if (nf >= 26)
    begin
      chk1(power.analog_pd, 1'b1, "analog after done");
      chk1(power.digital_pd, 1'b0, "digital after done");
    end
    ssa_host_model_i.end_frame(half);
    chk1(pin_out.dout_oe, 1'b0, "released");
    chk1(power.analog_pd, 1'b1, "analog select high");
    chk1(power.digital_pd, 1'b1, "digital select high");
    $display("frame of %0d falls done", nf);
  endtask

  //----------------------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    int nf;
    int j;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    chk1(pin_out.dout_oe, 1'b0, "reset enable");
    chk1(power.analog_pd, 1'b1, "reset analog");
    chk1(power.digital_pd, 1'b1, "reset digital");
    chk1(smp_ready, 1'b1, "reset ready");
    $display("reset test done");
    // Ideal codes and 7FF first, then random words until the buffer is full.
    push(CODE_FULL, 1'b1);
    push(CODE_MID, 1'b1);
    push(12'h7FF, 1'b1);
    push(CODE_ZERO, 1'b1);
    for (int i = 4; i < FIFO_DEPTH; i++)
    begin
      r = $random(seed);
      push(r[RES_W-1:0], 1'b1);
    end
    // A full buffer refuses the next word.
    push(12'h5A5, 1'b0);
    $display("fill test done");
    // Abort inside the sample window: no word may be consumed.
    run_frame(1, 5);
    j = 0;
    while (exp_q.size() > 0)
    begin
      r = $random(seed);
      nf = (j < 4 || r[3]) ? 30 : 2 + int'(r[7:4]);
      run_frame(nf, 5 + int'(r[1:0]));
      j++;
    end
    $display("drain test done");
    stop_test();
  end
endmodule
